// ---- verilog/dsh_pkg.sv ----
/*
 dsh_pkg: constants shared by both ends of the serial DAC host link.
 Assumes a 20 MHz system clock on both ends.
*/
// Function
// - device samples on fall, shifts out on rise
// - host sends words most significant bit first
// - host holds frame select low per word
// - host clock idles low, phase one
// - host data valid at each falling edge
// - word built from three bytes per frame
// - host launches data on rising edge
// - host makes clock, active-low framing
// - parallel: low address lines, decoded load strobe
// - reset selects external reference
// - control bits choose reference value, source
// - power-on wait, host issues startup reset
// - monitor mux routes one channel out
// - monitor mode takes over last channel
// - host enables monitor before routing channels
// - monitor address 63 floats monitor output
// - control write: select 00, address 001100
// - readback framed, out on rise, valid fall
`default_nettype none
package dsh_pkg;
    localparam int CLK_HZ       = 20000000;
    localparam int POR_MS       = 10;
    localparam int POR_CYCLES   = POR_MS * (CLK_HZ / 1000);
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_CYCLES   = (RST_PULSE_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int LOAD_NS      = 200;
    localparam int LOAD_CYCLES  = (LOAD_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int HALF_CYCLES  = 8;
    localparam int HALF_W       = 4;
    localparam int BYTE_BITS    = 8;
    localparam int WORD_BYTES   = 3;
    localparam int WORD_BITS    = BYTE_BITS * WORD_BYTES;
    localparam int BIT_W        = 5;
    localparam int ADDR_W       = 6;
    localparam int DATA_W       = 12;
    // word fields
    localparam int F_READ       = 23;
    localparam int F_ADDR_LO    = 16;
    localparam int F_SEL_LO     = 14;
    localparam logic [1:0] SEL_SFR = 2'h0;
    localparam logic [ADDR_W-1:0] CTRL_ADDR    = 6'h0c;
    localparam logic [ADDR_W-1:0] MON_SEL_ADDR = 6'h0a;
    localparam logic [ADDR_W-1:0] MON_OFF_CHAN = 6'h3f;
    localparam logic [ADDR_W-1:0] LAST_CHAN    = 6'h27;
    // control register bits
    localparam int CR_REF_VALUE = 10;
    localparam int CR_MON_EN    = 9;
    localparam int CR_INT_REF   = 8;
    localparam logic [DATA_W-1:0] CTRL_RESET = 12'h000;
    // host software port
    localparam logic [2:0] HR_CMD    = 3'h0;
    localparam logic [2:0] HR_LOAD   = 3'h1;
    localparam logic [2:0] HR_CLR    = 3'h2;
    localparam logic [2:0] HR_STATUS = 3'h0;
    localparam logic [2:0] HR_RX     = 3'h1;
    localparam int CMD_LSB_FIRST = 24;
    typedef enum logic [4:0] {
        H_BOOT  = 5'h01,
        H_IDLE  = 5'h02,
        H_LEAD  = 5'h04,
        H_SHIFT = 5'h08,
        H_TRAIL = 5'h10
    } dsh_state_e;
endpackage : dsh_pkg
`default_nettype wire

// ---- verilog/dsh_link_if.sv ----
/*
 dsh_link_if: serial and strobe wires between host and DAC device.
 Assumes the bench resolves nothing: all wires are one-way.
*/
`timescale 1ns/10ps
`default_nettype none
interface dsh_link_if;
    logic       syncN;
    logic       sclk;
    logic       mosi;
    logic       miso;
    logic       misoEn;
    logic       devResetN;
    logic       loadOutputsN;
    logic [5:0] channelAddress;
    modport host (output syncN, sclk, mosi, devResetN, loadOutputsN, channelAddress,
                  input miso, misoEn);
    modport dev  (input syncN, sclk, mosi, devResetN, loadOutputsN, channelAddress,
                  output miso, misoEn);
endinterface : dsh_link_if
`default_nettype wire

// ---- verilog/dsh_device.sv ----
/*
 dsh_device: DAC serial word slave with control and monitor registers.
 Assumes link pins are asynchronous to clk_sys and slow versus it.
*/
`timescale 1ns/10ps
`default_nettype none
module dsh_device
    import dsh_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // link
    dsh_link_if.dev                link,
    // user side
    output logic                   ready,
    output logic                   refInternal,
    output logic                   refValueHigh,
    output logic                   monitorActive,
    output logic                   monitorHiZ,
    output logic [ADDR_W-1:0]      monitorChannel,
    output logic                   loadPulse
);
    localparam int PW = $clog2(POR_CNT + 1);

    logic [2:0]           sclkS;
    logic [2:0]           syncS;
    logic [2:0]           loadS;
    logic [1:0]           rstS;
    logic [1:0]           dinS;
    logic [PW-1:0]        porCnt;
    logic [WORD_BITS-1:0] rxWord;
    logic [WORD_BITS-1:0] txWord;
    logic [WORD_BITS-1:0] rbWord;
    logic [BIT_W-1:0]     bitCnt;
    logic [DATA_W-1:0]    ctrl;
    logic [ADDR_W-1:0]    monChan;
    logic                 misoBit;
    logic                 misoDrv;

    // ***********************
    // pin synchronisers
    // ***********************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sclkS <= 3'h0;
            syncS <= 3'h7;
            loadS <= 3'h7;
            rstS  <= 2'h0;
            dinS  <= 2'h0;
        end else begin
            sclkS <= {sclkS[1:0], link.sclk};
            syncS <= {syncS[1:0], link.syncN};
            loadS <= {loadS[1:0], link.loadOutputsN};
            rstS  <= {rstS[0], link.devResetN};
            dinS  <= {dinS[0], link.mosi};
        end
    end

    // ***********************
    // decode
    // ***********************
    // fall samples, rise shifts
    wire sclkFall  = sclkS[2] & ~sclkS[1];
    wire sclkRise  = ~sclkS[2] & sclkS[1];
    wire frameOn   = ~syncS[1];
    wire frameBeg  = syncS[2] & ~syncS[1];
    wire devRst    = ~rstS[1];
    wire porDone   = (porCnt == PW'(POR_CNT));
    wire shiftEn   = sclkFall & frameOn & porDone;
    wire [WORD_BITS-1:0] nextRx = {rxWord[WORD_BITS-2:0], dinS[1]};
    wire wordDone  = shiftEn & (bitCnt == BIT_W'(WORD_BITS - 1));
    wire [ADDR_W-1:0] wAddr = nextRx[F_ADDR_LO +: ADDR_W];
    wire [1:0]        wSel  = nextRx[F_SEL_LO +: 2];
    wire [DATA_W-1:0] wData = nextRx[DATA_W-1:0];
    wire              wRead = nextRx[F_READ];
    wire isCtrl = (wSel == SEL_SFR) & (wAddr == CTRL_ADDR);
    wire isMon  = (wSel == SEL_SFR) & (wAddr == MON_SEL_ADDR);
    wire monOk  = (wData[ADDR_W-1:0] <= LAST_CHAN) | (wData[ADDR_W-1:0] == MON_OFF_CHAN);
    wire ctrlWr = wordDone & ~wRead & isCtrl;
    wire monWr  = wordDone & ~wRead & isMon & ctrl[CR_MON_EN] & monOk;
    wire [DATA_W-1:0] rbVal = isCtrl ? ctrl :
                              isMon  ? {{(DATA_W-ADDR_W){1'b0}}, monChan} : '0;

    // ***********************
    // power-on wait
    // ***********************
    // brownout hold
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            porCnt <= '0;
        end else if (devRst) begin
            porCnt <= '0;
        end else if (!porDone) begin
            porCnt <= porCnt + PW'(1);
        end
    end

    // ***********************
    // shift registers
    // ***********************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rxWord <= '0;
            bitCnt <= '0;
        end else if (frameBeg) begin
            bitCnt <= '0;
        end else if (shiftEn) begin
            rxWord <= nextRx;
            bitCnt <= bitCnt + BIT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            txWord  <= '0;
            rbWord  <= '0;
            misoBit <= 1'b0;
            misoDrv <= 1'b0;
        end else begin
            misoDrv <= frameOn;
            if (wordDone) begin
                rbWord <= wRead ? {2'h0, wAddr, wSel, 2'h0, rbVal} : '0;
            end
            if (frameBeg) begin
                txWord <= rbWord;
            end else if (sclkRise & frameOn) begin
                misoBit <= txWord[WORD_BITS-1];
                txWord  <= {txWord[WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // ***********************
    // control and monitor
    // ***********************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl    <= CTRL_RESET;
            monChan <= MON_OFF_CHAN;
        end else if (devRst) begin
            ctrl    <= CTRL_RESET;
            monChan <= MON_OFF_CHAN;
        end else begin
            if (ctrlWr) begin
                ctrl <= wData;
            end
            if (monWr) begin
                monChan <= wData[ADDR_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            loadPulse <= 1'b0;
        end else begin
            loadPulse <= loadS[2] & ~loadS[1];
        end
    end

    // ***********************
    // outputs
    // ***********************
    assign ready          = porDone;
    assign refInternal    = ctrl[CR_INT_REF];
    assign refValueHigh   = ctrl[CR_REF_VALUE];
    assign monitorActive  = ctrl[CR_MON_EN];
    assign monitorHiZ     = (monChan == MON_OFF_CHAN);
    assign monitorChannel = monChan;
    assign link.miso      = misoBit;
    assign link.misoEn    = misoDrv;
endmodule : dsh_device
`default_nettype wire

// ---- verilog/dsh_host.sv ----
/*
 dsh_host: serial master that sends 24-bit words to the DAC device.
 Assumes software uses the plain strobe port; reads answer next cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module dsh_host
    import dsh_pkg::*;
#(
    parameter int POR_CNT = POR_CYCLES
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // software port
    input  wire logic [2:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    output logic      [31:0] rdata,
    // link
    dsh_link_if.host         link
);
    // boot spans device reset, its sync lag and its power-on wait
    localparam int BOOT_END = POR_CNT + RST_CYCLES + HALF_CYCLES;
    localparam int PW       = $clog2(BOOT_END + 1);

    dsh_state_e           state;
    logic [PW-1:0]        bootCnt;
    logic [HALF_W-1:0]    div;
    logic [BIT_W-1:0]     bitCnt;
    logic [WORD_BITS-1:0] txWord;
    logic [WORD_BITS-1:0] rxWord;
    logic [WORD_BITS-1:0] rxData;
    logic [WORD_BITS-1:0] revWord;
    logic [3:0]           loadCnt;
    logic [1:0]           misoS;
    logic                 sclk;
    logic                 mosi;
    logic                 syncN;
    logic                 rstN;
    logic                 monShadow;
    logic                 err;
    logic [ADDR_W-1:0]    chanAddr;

    // ***********************
    // command decode
    // ***********************
    // optional bit reorder
    genvar gi;
    generate
        for (gi = 0; gi < WORD_BITS; gi++) begin : g_rev
            assign revWord[gi] = wdata[WORD_BITS-1-gi];
        end
    endgenerate
    wire [WORD_BITS-1:0] cmdWord = wdata[CMD_LSB_FIRST] ? revWord : wdata[WORD_BITS-1:0];
    wire [ADDR_W-1:0] cAddr = cmdWord[F_ADDR_LO +: ADDR_W];
    wire [1:0]        cSel  = cmdWord[F_SEL_LO +: 2];
    wire              cRead = cmdWord[F_READ];
    wire cCtrl  = ~cRead & (cSel == SEL_SFR) & (cAddr == CTRL_ADDR);
    wire cMon   = ~cRead & (cSel == SEL_SFR) & (cAddr == MON_SEL_ADDR);
    wire cmdWr  = wrEn & (addr == HR_CMD);
    wire idle   = (state == H_IDLE);
    wire refuse = cmdWr & (~idle | (cMon & ~monShadow));
    wire start  = cmdWr & ~refuse;
    wire loadWr = wrEn & (addr == HR_LOAD);
    wire clrWr  = wrEn & (addr == HR_CLR);
    wire tick   = (div == HALF_W'(HALF_CYCLES - 1));
    wire active = (state == H_LEAD) | (state == H_SHIFT) | (state == H_TRAIL);
    wire lastBit = (bitCnt == BIT_W'(WORD_BITS - 1));
    wire bootDone = (bootCnt == PW'(BOOT_END));
    wire [31:0] status = {29'h0, ~idle, bootDone, err};
    wire [31:0] rdMux  = (addr == HR_STATUS) ? status :
                         (addr == HR_RX) ? {8'h0, rxData} : 32'h0;

    // ***********************
    // boot and divider
    // ***********************
    // startup reset and wait
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bootCnt <= '0;
            rstN    <= 1'b0;
        end else begin
            rstN <= (bootCnt >= PW'(RST_CYCLES));
            if (!bootDone) begin
                bootCnt <= bootCnt + PW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div <= '0;
        end else if (!active || tick) begin
            div <= '0;
        end else begin
            div <= div + HALF_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            misoS <= 2'h0;
        end else begin
            misoS <= {misoS[0], link.miso};
        end
    end

    // ***********************
    // frame sequencer
    // ***********************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state  <= H_BOOT;
            sclk   <= 1'b0;
            mosi   <= 1'b0;
            syncN  <= 1'b1;
            bitCnt <= '0;
            txWord <= '0;
            rxWord <= '0;
            rxData <= '0;
        end else begin
            case (state)
                H_BOOT: begin
                    if (bootDone) begin
                        state <= H_IDLE;
                    end
                end
                H_IDLE: begin
                    if (start) begin
                        txWord <= cmdWord;
                        bitCnt <= '0;
                        syncN  <= 1'b0;
                        state  <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (tick) begin
                        state <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (tick && !sclk) begin
                        sclk   <= 1'b1;
                        mosi   <= txWord[WORD_BITS-1];
                        txWord <= {txWord[WORD_BITS-2:0], 1'b0};
                    end else if (tick) begin
                        sclk   <= 1'b0;
                        rxWord <= {rxWord[WORD_BITS-2:0], misoS[1]};
                        bitCnt <= bitCnt + BIT_W'(1);
                        if (lastBit) begin
                            state <= H_TRAIL;
                        end
                    end
                end
                H_TRAIL: begin
                    if (tick) begin
                        syncN  <= 1'b1;
                        rxData <= rxWord;
                        state  <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                    syncN <= 1'b1;
                    sclk  <= 1'b0;
                end
            endcase
        end
    end

    // ***********************
    // software registers
    // ***********************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            monShadow <= 1'b0;
            err       <= 1'b0;
            chanAddr  <= '0;
            loadCnt   <= '0;
            rdata     <= '0;
        end else begin
            if (start && cCtrl) begin
                monShadow <= cmdWord[CR_MON_EN];
            end
            if (start) begin
                chanAddr <= cAddr;
            end
            if (refuse) begin
                err <= 1'b1;
            end else if (clrWr) begin
                err <= 1'b0;
            end
            if (loadWr) begin
                loadCnt <= 4'(LOAD_CYCLES);
            end else if (loadCnt != 4'h0) begin
                loadCnt <= loadCnt - 4'h1;
            end
            rdata <= rdEn ? rdMux : 32'h0;
        end
    end

    // ***********************
    // link outputs
    // ***********************
    // clock idles low
    assign link.sclk           = sclk;
    assign link.mosi           = mosi;
    assign link.syncN          = syncN;
    assign link.devResetN      = rstN;
    assign link.loadOutputsN   = (loadCnt == 4'h0);
    assign link.channelAddress = chanAddr;
endmodule : dsh_host
`default_nettype wire

// ---- sim/dsh_assertions.sv ----
/*
 dsh_assertions: timing checks on the host-device link wires.
 Assumes the host's clk_sys and nrst; no other design state is seen.
*/
`timescale 1ns/10ps
`default_nettype none
module dsh_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // link
    input wire logic syncN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic misoEn,
    input wire logic devResetN,
    input wire logic loadOutputsN
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ****************************************
    // falls counted within one frame
    // ****************************************
    logic [5:0] nFall;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) nFall <= 6'h00;
        else if (syncN) nFall <= 6'h00;
        else if ($fell(sclk)) nFall <= nFall + 6'h01;
    end
    a_clock_idle_low: assert property (syncN |-> !sclk)
        else $error("shift clock high outside a frame");
    a_word_falls: assert property ($rose(syncN) |-> nFall == 6'h18)
        else $error("frame did not hold 24 falling edges");
    a_lead_gap: assert property ($fell(syncN) |-> !sclk[*8])
        else $error("clock started too soon after frame start");
    a_half_high: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
        else $error("shift clock high phase not 8 cycles");
    a_half_low: assert property ($fell(sclk) |-> !sclk[*8])
        else $error("shift clock low phase under 8 cycles");
    a_mosi_steady: assert property ($fell(sclk) |-> $stable(mosi))
        else $error("host data moved at falling edge");
    a_miso_steady: assert property ($fell(sclk) && misoEn |-> $stable(miso))
        else $error("device data moved at falling edge");
    a_miso_drive: assert property ($fell(syncN) |-> ##[1:4] misoEn)
        else $error("device did not drive readback line");
    a_load_width: assert property ($fell(loadOutputsN) |-> !loadOutputsN[*4] ##1 loadOutputsN)
        else $error("load strobe not 4 cycles low");
    a_reset_quiet: assert property (!devResetN |-> syncN)
        else $error("frame sent while device held in reset");
    c_frame: cover property ($rose(syncN));
    c_load: cover property ($fell(loadOutputsN));
    c_readback: cover property ($fell(sclk) && misoEn);
endmodule : dsh_assertions
`default_nettype wire

// ---- sim/dsh_bench.sv ----
/*
 dsh_bench: drives the host software port and checks the device outputs.
 Assumes both ends share clk_sys and nrst; power-on count cut to 100.
*/
`timescale 1ns/10ps
`default_nettype none
module dsh_bench;
    import dsh_pkg::*;
    localparam int POR_T = 100;
    localparam logic [23:0] RV_WORD = 24'h0c0500;
    logic              clk_sys;
    logic              nrst;
    logic [2:0]        addr;
    logic [31:0]       wdata;
    logic              wrEn;
    logic              rdEn;
    logic [31:0]       rdata;
    logic              ready;
    logic              refInternal;
    logic              refValueHigh;
    logic              monitorActive;
    logic              monitorHiZ;
    logic [ADDR_W-1:0] monitorChannel;
    logic              loadPulse;
    logic [31:0]       st;
    logic [23:0]       rv;
    logic [5:0]        mch [4] = '{6'h00, 6'h27, 6'h28, 6'h3f};
    logic [6:0]        mex [4] = '{7'h00, 7'h27, 7'h27, 7'h7f};
    int                bad_count = 0;
    int                n_compared = 0;
    int                nLoad = 0;
    int                n0;
    int                cyc = 0;
    dsh_link_if link ();
    dsh_host #(.POR_CNT(POR_T)) dsh_host_inst (.clk_sys(clk_sys), .nrst(nrst),
        .addr(addr), .wdata(wdata), .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .link(link));
    dsh_device #(.POR_CNT(POR_T)) dsh_device_inst (.clk_sys(clk_sys), .nrst(nrst),
        .link(link), .ready(ready), .refInternal(refInternal), .refValueHigh(refValueHigh),
        .monitorActive(monitorActive), .monitorHiZ(monitorHiZ),
        .monitorChannel(monitorChannel), .loadPulse(loadPulse));
    dsh_assertions dsh_assertions_inst (.clk_sys(clk_sys), .nrst(nrst), .syncN(link.syncN),
        .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .misoEn(link.misoEn),
        .devResetN(link.devResetN), .loadOutputsN(link.loadOutputsN));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (loadPulse === 1'b1) nLoad <= nLoad + 1;
        if (cyc == 40000) begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end
    // ****************************************
    // port tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wrEn  <= 1'b1;
        @(posedge clk_sys);
        wrEn  <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk_sys);
        rdEn <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic cmd(input logic [31:0] w);
        int i;
        i = 0;
        wr(HR_CMD, w);
        rd(HR_STATUS, st);
        while (st[2] !== 1'b0 && i < 2000) begin
            rd(HR_STATUS, st);
            i++;
        end
        repeat (8) @(posedge clk_sys);
    endtask : cmd
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        nrst  = 1'b0;
        addr  = 3'h0;
        wdata = 32'h0;
        wrEn  = 1'b0;
        rdEn  = 1'b0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1 chk(32'({refInternal, refValueHigh, monitorActive, monitorHiZ}), 32'h1);
        repeat (POR_T + 60) @(posedge clk_sys);
        rd(HR_STATUS, st);
        chk(st, 32'h2);
        chk(32'(ready), 32'h1);
        cmd(32'h000a0005);
        rd(HR_STATUS, st);
        chk(st, 32'h3);
        chk(32'(monitorChannel), 32'h3f);
        wr(HR_CLR, 32'h0);
        for (int k = 0; k < 4; k++) begin
            cmd(32'h000c0000 + 32'((k & 2) << 9) + 32'((k & 1) << 8));
            chk(32'({refValueHigh, refInternal}), 32'(k));
            chk(32'(link.channelAddress), 32'h0c);
        end
        cmd(32'h000c4000);
        chk(32'({refValueHigh, refInternal}), 32'h3);
        wr(HR_CMD, 32'h000c0200);
        wr(HR_CMD, 32'h000c0000);
        cmd(32'h00000000);
        rd(HR_STATUS, st);
        chk(st, 32'h3);
        chk(32'({monitorActive, refInternal}), 32'h2);
        wr(HR_CLR, 32'h0);
        for (int k = 0; k < 4; k++) begin
            cmd(32'h000a0000 | 32'(mch[k]));
            chk(32'({monitorHiZ, monitorChannel}), 32'(mex[k]));
        end
        cmd(32'h008c0000);
        cmd(32'h008a0000);
        rd(HR_RX, st);
        chk(st, 32'h000c0200);
        cmd(32'h000d0000);
        rd(HR_RX, st);
        chk(st, 32'h000a003f);
        for (int i = 0; i < 24; i++) rv[i] = RV_WORD[23 - i];
        cmd({7'h0, 1'b1, rv});
        chk(32'({refValueHigh, refInternal, monitorActive}), 32'h6);
        n0 = nLoad;
        wr(HR_LOAD, 32'h0);
        repeat (20) @(posedge clk_sys);
        chk(32'(nLoad - n0), 32'h1);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1 chk(32'({ready, refInternal, refValueHigh, monitorHiZ}), 32'h1);
        end_sim();
    end
endmodule : dsh_bench
`default_nettype wire
